// ==== epm_pkg.sv ====
package epm_pkg;

    // ----------------
    // address map
    // ----------------
    localparam logic [15:0] MAIN_RAM_LAST = 16'h3fff;
    localparam int MAIN_RAM_BYTES = 16384;
    localparam logic [15:0] SCRATCH_BASE = 16'he000;
    localparam logic [15:0] SCRATCH_LAST = 16'he1ff;
    localparam int SCRATCH_BYTES = 512;
    localparam logic [15:0] WAVE_BASE = 16'he400;
    localparam logic [15:0] WAVE_LAST = 16'he47f;
    localparam int WAVE_BYTES = 128;
    localparam logic [15:0] REGWIN_BASE = 16'he500;
    localparam logic [15:0] REGWIN_LAST = 16'he6ff;
    localparam logic [15:0] SETUP_BASE = 16'he6b8;
    localparam logic [15:0] SETUP_LAST = 16'he6bf;
    localparam logic [15:0] EP0_BASE = 16'he740;
    localparam logic [15:0] EP1OUT_BASE = 16'he780;
    localparam logic [15:0] EP1IN_BASE = 16'he7c0;
    localparam logic [15:0] EP1IN_LAST = 16'he7ff;
    localparam logic [15:0] EPBIG_BASE = 16'hf000;
    localparam int SMALL_EP_BYTES = 64;
    localparam int SMALL_RAM_BYTES = 192;
    localparam int BLOCK_BYTES = 512;
    localparam int N_BLOCKS = 8;
    localparam int BIG_RAM_BYTES = 4096;

    // ----------------
    // packet sizes and arrangements
    // ----------------
    localparam logic [9:0] HS_MAX_PKT = 10'h200;
    localparam logic [9:0] FS_MAX_PKT = 10'h040;
    localparam logic [9:0] EP1_PHYS_BYTES = 10'h040;
    localparam logic [3:0] N_CONFIGS = 4'hc;

    // sie endpoint select codes
    localparam logic [2:0] EP_0 = 3'h0;
    localparam logic [2:0] EP_1OUT = 3'h1;
    localparam logic [2:0] EP_1IN = 3'h2;
    localparam logic [2:0] EP_BIG0 = 3'h3;

    typedef enum logic [2:0] {
        EPM_TY_OFF = 3'h0,
        EPM_TY_CTRL = 3'h1,
        EPM_TY_BULK = 3'h2,
        EPM_TY_INT = 3'h3,
        EPM_TY_ISO = 3'h4
    } epm_type_t;

    typedef enum logic [3:0] {
        EPM_RG_NONE = 4'h0,
        EPM_RG_MAIN = 4'h1,
        EPM_RG_SCRATCH = 4'h2,
        EPM_RG_WAVE = 4'h3,
        EPM_RG_REGS = 4'h4,
        EPM_RG_SETUP = 4'h5,
        EPM_RG_EPSMALL = 4'h6,
        EPM_RG_EPBIG = 4'h7
    } epm_region_t;

    // map a data-space address onto the region that holds it
    function automatic epm_region_t epm_decode(input logic [15:0] a);
        epm_region_t r;
        r = EPM_RG_NONE;
        if (a <= MAIN_RAM_LAST)
            r = EPM_RG_MAIN;
        else if (a >= SCRATCH_BASE && a <= SCRATCH_LAST)
            r = EPM_RG_SCRATCH;
        else if (a >= WAVE_BASE && a <= WAVE_LAST)
            r = EPM_RG_WAVE;
        else if (a >= SETUP_BASE && a <= SETUP_LAST)
            r = EPM_RG_SETUP;
        else if (a >= REGWIN_BASE && a <= REGWIN_LAST)
            r = EPM_RG_REGS;
        else if (a >= EP0_BASE && a <= EP1IN_LAST)
            r = EPM_RG_EPSMALL;
        else if (a >= EPBIG_BASE)
            r = EPM_RG_EPBIG;
        return r;
    endfunction : epm_decode

endpackage : epm_pkg

// ==== epm_cfg.sv ====
`timescale 1ns/100ps
`default_nettype none

// endpoint attributes from buffer arrangement, alternate setting and speed
module epm_cfg (
    input wire logic hs_mode,
    input wire logic [1:0] alt_setting,
    input wire logic [3:0] buf_config,
    output logic cfg_valid,
    output logic [20:0] ep_type,
    output logic [69:0] ep_maxpkt,
    output logic [11:0] big_base,
    output logic [3:0] big_dbl,
    output logic [11:0] big_depth
);

    // ----------------
    // arrangement table: per ep2/4/6/8 {1024-byte buffer, depth}
    // ----------------
    function automatic logic [15:0] arrangement(input logic [3:0] sel);
        logic [15:0] t;
        t = 16'h0000;
        case (sel)
            4'h0: t = 16'h2222;
            4'h1: t = 16'h2240;
            4'h2: t = 16'h22a0;
            4'h3: t = 16'h3230;
            4'h4: t = 16'h4040;
            4'h5: t = 16'h40a0;
            4'h6: t = 16'ha040;
            4'h7: t = 16'ha0a0;
            4'h8: t = 16'h3032;
            4'h9: t = 16'h30a0;
            4'ha: t = 16'hb020;
            4'hb: t = 16'hc000;
            default: t = 16'h0000;
        endcase
        return t;
    endfunction : arrangement

    logic [15:0] arr;
    logic [3:0] used [0:4];

    // [RULE_10] one arrangement only
    assign cfg_valid = buf_config < epm_pkg::N_CONFIGS;
    assign arr = cfg_valid ? arrangement(buf_config) : 16'h0000;
    assign used[0] = 4'h0;

    // control endpoint 0 and the bulk/interrupt endpoint 1 pair
    // [RULE_08] endpoint kinds fixed
    assign ep_type[2:0] = epm_pkg::EPM_TY_CTRL;
    assign ep_maxpkt[9:0] = epm_pkg::FS_MAX_PKT;
    genvar g;
    generate
        for (g = 1; g < 3; g++)
        begin : g_ep1
            // [RULE_16] reported 512 in hs setting 1
            assign ep_type[g*3 +: 3] = (alt_setting == 2'h0) ? epm_pkg::EPM_TY_OFF :
                (alt_setting == 2'h1) ? epm_pkg::EPM_TY_BULK : epm_pkg::EPM_TY_INT;
            assign ep_maxpkt[g*10 +: 10] = (alt_setting == 2'h0) ? 10'h000 :
                (hs_mode && alt_setting == 2'h1) ? epm_pkg::HS_MAX_PKT
                : epm_pkg::EP1_PHYS_BYTES;
        end
        // endpoints 2, 4, 6 and 8
        for (g = 0; g < 4; g++)
        begin : g_big
            logic [2:0] dep;
            logic dbl;
            logic [3:0] blks;
            assign dep = arr[(3-g)*4 +: 3];
            assign dbl = arr[(3-g)*4 + 3];
            assign blks = dbl ? {dep, 1'b0} : {1'b0, dep};
            // [RULE_06] blocks packed from block zero
            assign used[g+1] = used[g] + blks;
            assign big_base[g*3 +: 3] = used[g][2:0];
            assign big_dbl[g] = dbl;
            // [RULE_07] depth per endpoint
            assign big_depth[g*3 +: 3] = dep;
            // [RULE_14] [RULE_15] default alternate settings
            assign ep_type[(g+3)*3 +: 3] = (dep == 3'h0 || alt_setting == 2'h0) ?
                epm_pkg::EPM_TY_OFF : (alt_setting == 2'h1 || g == 1 || g == 3) ?
                epm_pkg::EPM_TY_BULK : (alt_setting == 2'h2) ? epm_pkg::EPM_TY_INT
                : epm_pkg::EPM_TY_ISO;
            // [RULE_11] speed limit on packet
            assign ep_maxpkt[(g+3)*10 +: 10] = (ep_type[(g+3)*3 +: 3] == epm_pkg::EPM_TY_OFF)
                ? 10'h000 : (hs_mode ? epm_pkg::HS_MAX_PKT : epm_pkg::FS_MAX_PKT);
        end
    endgenerate

endmodule : epm_cfg

`default_nettype wire

// ==== epm_map.sv ====
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// [RULE_01] 16 kB code/data RAM at zero
// [RULE_02] loader paths reach only main and scratch
// [RULE_03] register window E500 to E6FF
// [RULE_04] waveform memory E400 to E47F, rest reserved
// [RULE_05] three 64-byte buffers, endpoints 0 and 1
// [RULE_06] eight 512-byte blocks at F000 to FFFF
// [RULE_07] ep4, ep8 double; ep2, ep6 up to quad
// [RULE_08] ep0 control, ep1 bulk/int, others any
// [RULE_09] setup bytes held at E6B8 to E6BF
// [RULE_10] exactly one of twelve arrangements
// [RULE_11] max packet 512 hs, 64 fs
// [RULE_12] full speed uses first 64 bytes
// [RULE_13] full speed leftover never reused
// [RULE_14] default full speed alternate settings
// [RULE_15] default high speed alternate settings
// [RULE_16] ep1 reports 512, holds 64
// [RULE_17] reserved regions: writes ignored, reads zero
module epm_map (
    input wire logic mclk,
    input wire logic sys_rst,
    // processor data-space port
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic cpu_rvalid,
    output logic cpu_stall,
    // outer control/status register file
    output logic reg_sel,
    output logic reg_wr,
    output logic [8:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // download, upload, setup pointer and boot loader port
    input wire logic [15:0] ldr_addr,
    input wire logic ldr_rd,
    input wire logic ldr_wr,
    input wire logic [7:0] ldr_wdata,
    output logic [7:0] ldr_rdata,
    output logic ldr_rvalid,
    output logic ldr_err,
    // serial engine buffer port
    input wire logic [2:0] sie_ep,
    input wire logic [1:0] sie_buf,
    input wire logic [9:0] sie_ofs,
    input wire logic sie_rd,
    input wire logic sie_wr,
    input wire logic [7:0] sie_wdata,
    output logic [7:0] sie_rdata,
    output logic sie_rvalid,
    output logic sie_err,
    input wire logic sie_setup_wr,
    input wire logic [2:0] sie_setup_idx,
    input wire logic [7:0] sie_setup_data,
    // endpoint arrangement
    input wire logic hs_mode,
    input wire logic [1:0] alt_setting,
    input wire logic [3:0] buf_config,
    output logic cfg_valid,
    output logic [20:0] ep_type,
    output logic [69:0] ep_maxpkt,
    output logic [11:0] big_depth
);

    // ----------------
    // memories
    // ----------------
    logic [7:0] main_ram [0:epm_pkg::MAIN_RAM_BYTES-1];
    logic [7:0] scratch_ram [0:epm_pkg::SCRATCH_BYTES-1];
    logic [7:0] wave_ram [0:epm_pkg::WAVE_BYTES-1];
    logic [7:0] setup_buf [0:7];
    logic [7:0] small_ram [0:epm_pkg::SMALL_RAM_BYTES-1];
    logic [7:0] big_ram [0:epm_pkg::BIG_RAM_BYTES-1];

    logic [11:0] big_base;
    logic [3:0] big_dbl;
    epm_pkg::epm_region_t cpu_rg;
    epm_pkg::epm_region_t ldr_rg;
    logic ldr_ok;
    logic ldr_go;
    logic cpu_go_wr;
    logic sie_go;
    logic sie_small;
    logic sie_ok;
    logic [7:0] sie_small_idx;
    logic [11:0] sie_big_idx;
    logic [1:0] k;
    logic [2:0] dep;
    logic [9:0] limit;
    logic [11:0] buf_start;
    logic [7:0] cpu_small_idx;

    // ----------------
    // endpoint arrangement
    // ----------------
    epm_cfg u_cfg (
        .hs_mode(hs_mode),
        .alt_setting(alt_setting),
        .buf_config(buf_config),
        .cfg_valid(cfg_valid),
        .ep_type(ep_type),
        .ep_maxpkt(ep_maxpkt),
        .big_base(big_base),
        .big_dbl(big_dbl),
        .big_depth(big_depth)
    );

    // ----------------
    // address decode
    // ----------------
    // [RULE_01] [RULE_03] [RULE_04] region decode
    assign cpu_rg = epm_pkg::epm_decode(cpu_addr);
    assign ldr_rg = epm_pkg::epm_decode(ldr_addr);
    // [RULE_02] loader limited to two RAMs
    assign ldr_ok = (ldr_rg == epm_pkg::EPM_RG_MAIN) || (ldr_rg == epm_pkg::EPM_RG_SCRATCH);
    assign ldr_go = ldr_wr && ldr_ok;
    // endpoint 0 at the first 64 bytes, then ep1 out, then ep1 in
    assign cpu_small_idx = 8'(cpu_addr - epm_pkg::EP0_BASE);

    // ----------------
    // serial engine buffer addressing
    // ----------------
    assign sie_small = sie_ep < epm_pkg::EP_BIG0;
    assign k = 2'(sie_ep - epm_pkg::EP_BIG0);
    assign dep = big_depth[k*3 +: 3];
    // [RULE_12] full speed window of 64 bytes
    assign limit = !hs_mode ? epm_pkg::FS_MAX_PKT :
        (big_dbl[k] ? 10'h3ff : 10'h1ff);
    assign buf_start = 12'({big_base[k*3 +: 3], 9'h000}) +
        12'(big_dbl[k] ? {sie_buf, 10'h000} : {1'b0, sie_buf, 9'h000});
    assign sie_big_idx = buf_start + 12'(sie_ofs);
    // [RULE_05] [RULE_16] ep1 holds 64 bytes only
    assign sie_small_idx = {sie_ep[1:0], sie_ofs[5:0]};
    // [RULE_13] leftover space refused to the engine
    assign sie_ok = (sie_ep <= 3'h6) && (sie_small ? (sie_ofs < 10'(epm_pkg::SMALL_EP_BYTES))
        : (cfg_valid && dep != 3'h0 && 3'(sie_buf) < dep && sie_ofs <= limit
        && (hs_mode || sie_ofs < epm_pkg::FS_MAX_PKT)));
    assign sie_go = sie_wr && sie_ok;

    // ----------------
    // processor stalls on a clash with the engine or loader
    // ----------------
    assign cpu_stall = (cpu_rd || cpu_wr) &&
        (((sie_rd || sie_wr) && sie_ok &&
          ((sie_small && cpu_rg == epm_pkg::EPM_RG_EPSMALL) ||
           (!sie_small && cpu_rg == epm_pkg::EPM_RG_EPBIG))) ||
         (sie_setup_wr && cpu_rg == epm_pkg::EPM_RG_SETUP) ||
         ((ldr_rd || ldr_wr) && ldr_ok && cpu_rg == ldr_rg));
    assign cpu_go_wr = cpu_wr && !cpu_stall;

    // register window strobes to the outer register file
    // [RULE_03] window passed out
    assign reg_sel = (cpu_rd || cpu_wr) && (cpu_rg == epm_pkg::EPM_RG_REGS);
    assign reg_wr = cpu_wr && (cpu_rg == epm_pkg::EPM_RG_REGS);
    assign reg_addr = 9'(cpu_addr - epm_pkg::REGWIN_BASE);
    assign reg_wdata = cpu_wdata;

    // ----------------
    // main and scratch RAM writes, loader first
    // ----------------
    // [RULE_01] code/data RAM
    always_ff @(posedge mclk)
    begin
        if (ldr_go && ldr_rg == epm_pkg::EPM_RG_MAIN)
            main_ram[ldr_addr[13:0]] <= ldr_wdata;
        else if (cpu_go_wr && cpu_rg == epm_pkg::EPM_RG_MAIN)
            main_ram[cpu_addr[13:0]] <= cpu_wdata;
    end

    always_ff @(posedge mclk)
    begin
        if (ldr_go && ldr_rg == epm_pkg::EPM_RG_SCRATCH)
            scratch_ram[ldr_addr[8:0]] <= ldr_wdata;
        else if (cpu_go_wr && cpu_rg == epm_pkg::EPM_RG_SCRATCH)
            scratch_ram[cpu_addr[8:0]] <= cpu_wdata;
    end

    // [RULE_04] waveform memory, processor only
    always_ff @(posedge mclk)
    begin
        if (cpu_go_wr && cpu_rg == epm_pkg::EPM_RG_WAVE)
            wave_ram[cpu_addr[6:0]] <= cpu_wdata;
    end

    // [RULE_09] setup bytes from the engine
    always_ff @(posedge mclk)
    begin
        if (sie_setup_wr)
            setup_buf[sie_setup_idx] <= sie_setup_data;
        else if (cpu_go_wr && cpu_rg == epm_pkg::EPM_RG_SETUP)
            setup_buf[cpu_addr[2:0]] <= cpu_wdata;
    end

    // ----------------
    // endpoint buffer writes, engine first
    // ----------------
    // [RULE_05] small endpoint buffers
    always_ff @(posedge mclk)
    begin
        if (sie_go && sie_small)
            small_ram[sie_small_idx] <= sie_wdata;
        else if (cpu_go_wr && cpu_rg == epm_pkg::EPM_RG_EPSMALL)
            small_ram[cpu_small_idx] <= cpu_wdata;
    end

    // [RULE_06] block buffers
    always_ff @(posedge mclk)
    begin
        if (sie_go && !sie_small)
            big_ram[sie_big_idx] <= sie_wdata;
        else if (cpu_go_wr && cpu_rg == epm_pkg::EPM_RG_EPBIG)
            big_ram[cpu_addr[11:0]] <= cpu_wdata;
    end

    // ----------------
    // processor read data, one cycle after the request
    // ----------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            cpu_rdata <= 8'h00;
            cpu_rvalid <= 1'b0;
        end
        else
        begin
            cpu_rvalid <= cpu_rd && !cpu_stall;
            if (cpu_rd && !cpu_stall)
            begin
                case (cpu_rg)
                    epm_pkg::EPM_RG_MAIN: cpu_rdata <= main_ram[cpu_addr[13:0]];
                    epm_pkg::EPM_RG_SCRATCH: cpu_rdata <= scratch_ram[cpu_addr[8:0]];
                    epm_pkg::EPM_RG_WAVE: cpu_rdata <= wave_ram[cpu_addr[6:0]];
                    epm_pkg::EPM_RG_SETUP: cpu_rdata <= setup_buf[cpu_addr[2:0]];
                    epm_pkg::EPM_RG_REGS: cpu_rdata <= reg_rdata;
                    epm_pkg::EPM_RG_EPSMALL: cpu_rdata <= small_ram[cpu_small_idx];
                    epm_pkg::EPM_RG_EPBIG: cpu_rdata <= big_ram[cpu_addr[11:0]];
                    // [RULE_17] reserved reads zero
                    default: cpu_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ----------------
    // loader read data and refusal flag
    // ----------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ldr_rdata <= 8'h00;
            ldr_rvalid <= 1'b0;
            ldr_err <= 1'b0;
        end
        else
        begin
            ldr_rvalid <= ldr_rd;
            // [RULE_02] other regions refused
            ldr_err <= (ldr_rd || ldr_wr) && !ldr_ok;
            if (ldr_rd)
            begin
                if (ldr_rg == epm_pkg::EPM_RG_MAIN)
                    ldr_rdata <= main_ram[ldr_addr[13:0]];
                else if (ldr_rg == epm_pkg::EPM_RG_SCRATCH)
                    ldr_rdata <= scratch_ram[ldr_addr[8:0]];
                else
                    ldr_rdata <= 8'h00;
            end
        end
    end

    // ----------------
    // engine read data and refusal flag
    // ----------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            sie_rdata <= 8'h00;
            sie_rvalid <= 1'b0;
            sie_err <= 1'b0;
        end
        else
        begin
            sie_rvalid <= sie_rd;
            // [RULE_12] out-of-window access flagged
            sie_err <= (sie_rd || sie_wr) && !sie_ok;
            if (sie_rd)
            begin
                if (!sie_ok)
                    sie_rdata <= 8'h00;
                else if (sie_small)
                    sie_rdata <= small_ram[sie_small_idx];
                else
                    sie_rdata <= big_ram[sie_big_idx];
            end
        end
    end

endmodule : epm_map

`default_nettype wire

// ==== epm_far_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// outer control/status register file seen through the register window
module epm_far_model (
    input wire logic mclk,
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata
);
    logic [7:0] mem [512];

    // known start pattern: low byte of the offset
    initial
    begin
        for (int i = 0; i < 512; i++)
            mem[i] = i[7:0];
    end

    always_ff @(posedge mclk)
    begin
        if (reg_sel && reg_wr)
            mem[reg_addr] <= reg_wdata;
    end

    // unselected: inverse of the stored byte, never a held value
    assign reg_rdata = reg_sel ? mem[reg_addr] : ~mem[reg_addr];
endmodule : epm_far_model

`default_nettype wire

// ==== epm_map_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none

// port checks of the memory map
module epm_map_assertions (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic [7:0] cpu_rdata,
    input wire logic cpu_rvalid,
    input wire logic cpu_stall,
    input wire logic reg_sel,
    input wire logic [8:0] reg_addr,
    input wire logic [15:0] ldr_addr,
    input wire logic ldr_rd,
    input wire logic ldr_wr,
    input wire logic ldr_err,
    input wire logic [2:0] sie_ep,
    input wire logic [9:0] sie_ofs,
    input wire logic sie_rd,
    input wire logic sie_wr,
    input wire logic sie_err,
    input wire logic hs_mode,
    input wire logic [1:0] alt_setting,
    input wire logic [3:0] buf_config,
    input wire logic cfg_valid,
    input wire logic [20:0] ep_type,
    input wire logic [69:0] ep_maxpkt
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_rd;
        cpu_rd && !cpu_stall |=> cpu_rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("cpu read not answered");
    property p_reg;
        (cpu_rd || cpu_wr) && cpu_addr inside {[16'he500:16'he6b7], [16'he6c0:16'he6ff]}
            |-> reg_sel && reg_addr == cpu_addr[8:0] - 9'h100;
    endproperty
    a_reg: assert property (p_reg) else $error("register window decode");
    property p_setup;
        cpu_addr inside {[16'he6b8:16'he6bf]} |-> !reg_sel;
    endproperty
    a_setup: assert property (p_setup) else $error("setup bytes in register file");
    property p_rsv;
        cpu_rd && !cpu_stall && cpu_addr inside {[16'he480:16'he4ff], [16'he200:16'he3ff]}
            |=> cpu_rvalid && cpu_rdata == 8'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved read not zero");
    property p_ldr_bad;
        (ldr_rd || ldr_wr) && !(ldr_addr inside {[16'h0000:16'h3fff], [16'he000:16'he1ff]})
            |=> ldr_err;
    endproperty
    a_ldr_bad: assert property (p_ldr_bad) else $error("loader reached other region");
    property p_ldr_ok;
        (ldr_rd || ldr_wr) && ldr_addr inside {[16'h0000:16'h3fff], [16'he000:16'he1ff]}
            |=> !ldr_err;
    endproperty
    a_ldr_ok: assert property (p_ldr_ok) else $error("loader refused ram");
    property p_small;
        (sie_rd || sie_wr) && sie_ep <= 3'h2 && sie_ofs >= 10'h040 |=> sie_err;
    endproperty
    a_small: assert property (p_small) else $error("small buffer overrun");
    property p_fs;
        (sie_rd || sie_wr) && !hs_mode && sie_ep inside {[3'h3:3'h6]} && sie_ofs >= 10'h040
            |=> sie_err;
    endproperty
    a_fs: assert property (p_fs) else $error("full speed beyond 64");
    property p_cfg;
        cfg_valid == (buf_config < 4'hc);
    endproperty
    a_cfg: assert property (p_cfg) else $error("arrangement validity");
    property p_ep0;
        ep_type[2:0] == 3'h1 && ep_maxpkt[9:0] == 10'h040 && ep_type[5:3] inside {0, 2, 3};
    endproperty
    a_ep0: assert property (p_ep0) else $error("endpoint 0 or 1 type");
    property p_ep1;
        hs_mode && alt_setting == 2'h1 |-> ep_maxpkt[29:10] == {10'h200, 10'h200};
    endproperty
    a_ep1: assert property (p_ep1) else $error("ep1 report size");
    property p_fsmax;
        !hs_mode |-> ep_maxpkt[39:30] <= 10'h040 && ep_maxpkt[59:50] <= 10'h040;
    endproperty
    a_fsmax: assert property (p_fsmax) else $error("full speed packet size");
endmodule : epm_map_assertions

bind epm_map epm_map_assertions chk_u (.mclk, .sys_rst, .cpu_addr, .cpu_rd, .cpu_wr,
    .cpu_rdata, .cpu_rvalid, .cpu_stall, .reg_sel, .reg_addr, .ldr_addr, .ldr_rd, .ldr_wr,
    .ldr_err, .sie_ep, .sie_ofs, .sie_rd, .sie_wr, .sie_err, .hs_mode, .alt_setting,
    .buf_config, .cfg_valid, .ep_type, .ep_maxpkt);

`default_nettype wire

// ==== epm_map_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end

module epm_map_test;
    int n_errors = 0;
    int samples_checked = 0;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] cpu_addr = 16'h0000, ldr_addr = 16'h0000;
    logic cpu_rd = 1'b0, cpu_wr = 1'b0, ldr_rd = 1'b0, ldr_wr = 1'b0;
    logic [7:0] cpu_wdata = 8'h00, ldr_wdata = 8'h00, sie_wdata = 8'h00, sie_setup_data = 8'h00;
    logic [2:0] sie_ep = 3'h0, sie_setup_idx = 3'h0;
    logic [1:0] sie_buf = 2'h0, alt_setting = 2'h0;
    logic [9:0] sie_ofs = 10'h000;
    logic sie_rd = 1'b0, sie_wr = 1'b0, sie_setup_wr = 1'b0, hs_mode = 1'b1;
    logic [3:0] buf_config = 4'h0;
    logic [7:0] cpu_rdata, reg_wdata, reg_rdata, ldr_rdata, sie_rdata, got;
    logic cpu_rvalid, cpu_stall, reg_sel, reg_wr, ldr_rvalid, ldr_err, sie_rvalid, sie_err;
    logic cfg_valid, vld, err;
    logic [8:0] reg_addr;
    logic [20:0] ep_type;
    logic [69:0] ep_maxpkt;
    logic [11:0] big_depth;

    always #50 mclk = ~mclk;

    epm_map dut_u (.mclk, .sys_rst, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata,
        .cpu_rvalid, .cpu_stall, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
        .ldr_addr, .ldr_rd, .ldr_wr, .ldr_wdata, .ldr_rdata, .ldr_rvalid, .ldr_err, .sie_ep,
        .sie_buf, .sie_ofs, .sie_rd, .sie_wr, .sie_wdata, .sie_rdata, .sie_rvalid, .sie_err,
        .sie_setup_wr, .sie_setup_idx, .sie_setup_data, .hs_mode, .alt_setting, .buf_config,
        .cfg_valid, .ep_type, .ep_maxpkt, .big_depth);
    epm_far_model far_u (.mclk, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata);

    // one access per port, answer captured in the cycle after the edge
    task automatic cpu(input logic [15:0] a, input logic w, input logic [7:0] d);
        cpu_addr = a; cpu_rd = !w; cpu_wr = w; cpu_wdata = d;
        @(posedge mclk) #1;
        cpu_rd = 1'b0; cpu_wr = 1'b0; got = cpu_rdata; vld = cpu_rvalid;
        @(posedge mclk) #1;
    endtask : cpu
    task automatic ldr(input logic [15:0] a, input logic w, input logic [7:0] d);
        ldr_addr = a; ldr_rd = !w; ldr_wr = w; ldr_wdata = d;
        @(posedge mclk) #1;
        ldr_rd = 1'b0; ldr_wr = 1'b0; got = ldr_rdata; vld = ldr_rvalid; err = ldr_err;
        @(posedge mclk) #1;
    endtask : ldr
    task automatic sie(input logic [2:0] e, input logic [1:0] b, input logic [9:0] o,
        input logic w, input logic [7:0] d);
        sie_ep = e; sie_buf = b; sie_ofs = o; sie_rd = !w; sie_wr = w; sie_wdata = d;
        @(posedge mclk) #1;
        sie_rd = 1'b0; sie_wr = 1'b0; got = sie_rdata; vld = sie_rvalid; err = sie_err;
        @(posedge mclk) #1;
    endtask : sie

    // main and waveform ram keep data; reserved reads zero
    task automatic t_ram;
        logic [15:0] rsv [5] = '{16'he480, 16'he200, 16'he700, 16'he800, 16'h4000};
        cpu(16'h0000, 1, 8'ha5); cpu(16'h3fff, 1, 8'h3c); cpu(16'he47f, 1, 8'h77);
        cpu(16'h0000, 0, 8'h00); `CHK(got, 8'ha5)
        cpu(16'h3fff, 0, 8'h00); `CHK({vld, got}, 9'h13c)
        cpu(16'he47f, 0, 8'h00); `CHK(got, 8'h77)
        foreach (rsv[i])
        begin
            cpu(rsv[i], 1, 8'hff); cpu(rsv[i], 0, 8'h00);
            `CHK({vld, got}, 9'h100)
        end
    endtask : t_ram

    // register window strobes and setup buffer kept apart
    task automatic t_regs;
        cpu_addr = 16'he600; cpu_wr = 1'b1; cpu_wdata = 8'hc3;
        #1 `CHK({reg_sel, reg_wr, reg_addr}, 11'h700)
        @(posedge mclk) #1;
        cpu(16'he600, 0, 8'h00); `CHK(got, 8'hc3)
        cpu(16'he6ff, 0, 8'h00); `CHK(got, 8'hff)
        cpu(16'he743, 1, 8'h11);
        cpu_addr = 16'he6bb; cpu_rd = 1'b1;
        sie_setup_wr = 1'b1; sie_setup_idx = 3'h3; sie_setup_data = 8'h9e;
        #1 `CHK(cpu_stall, 1'b1)
        @(posedge mclk) #1 sie_setup_wr = 1'b0;
        cpu(16'he6bb, 0, 8'h00); `CHK(got, 8'h9e)
        cpu(16'he743, 0, 8'h00); `CHK(got, 8'h11)
    endtask : t_regs

    // loader reaches main and scratch only, elsewhere no side effect
    task automatic t_loader;
        ldr(16'h0010, 1, 8'h6b); `CHK(err, 1'b0)
        cpu(16'h0010, 0, 8'h00); `CHK(got, 8'h6b)
        ldr(16'he1f0, 1, 8'h2d); ldr(16'he1f0, 0, 8'h00); `CHK({vld, got, err}, 10'h25a)
        cpu(16'hf000, 1, 8'h12); ldr(16'hf000, 1, 8'h55); `CHK(err, 1'b1)
        ldr(16'hf000, 0, 8'h00); `CHK({got, err}, 9'h001)
        cpu(16'hf000, 0, 8'h00); `CHK(got, 8'h12)
    endtask : t_loader

    // engine buffers: placement, depths and full speed limit
    task automatic t_sie;
        cpu(16'he745, 1, 8'h21); sie(3'h0, 2'h0, 10'h005, 0, 8'h00);
        `CHK({vld, got, err}, 10'h242)
        sie(3'h1, 2'h0, 10'h040, 0, 8'h00); `CHK(err, 1'b1)
        sie(3'h2, 2'h0, 10'h03f, 1, 8'h5e); cpu(16'he7ff, 0, 8'h00); `CHK(got, 8'h5e)
        sie(3'h3, 2'h1, 10'h005, 1, 8'h4d); cpu(16'hf205, 0, 8'h00); `CHK(got, 8'h4d)
        sie(3'h6, 2'h1, 10'h1ff, 1, 8'h88); cpu(16'hffff, 0, 8'h00); `CHK(got, 8'h88)
        sie(3'h4, 2'h2, 10'h000, 1, 8'h00); `CHK(err, 1'b1)
        sie(3'h7, 2'h0, 10'h000, 0, 8'h00); `CHK(err, 1'b1)
        buf_config = 4'hb;
        sie(3'h3, 2'h3, 10'h3ff, 1, 8'h99); `CHK(err, 1'b0)
        cpu(16'hffff, 0, 8'h00); `CHK(got, 8'h99)
        hs_mode = 1'b0;
        sie(3'h3, 2'h0, 10'h03f, 1, 8'h01); `CHK(err, 1'b0)
        sie(3'h3, 2'h0, 10'h040, 1, 8'h01); `CHK(err, 1'b1)
        buf_config = 4'h0; hs_mode = 1'b1;
    endtask : t_sie

    // arrangement depths and alternate setting attributes
    task automatic t_cfg;
        logic [3:0] c [4] = '{4'h0, 4'h4, 4'hb, 4'hc};
        logic [11:0] d [4] = '{12'h492, 12'h104, 12'h004, 12'h000};
        logic [20:0] ty [4] = '{21'h000001, 21'h092491, 21'h09a6d9, 21'h0a28d9};
        foreach (c[i])
        begin
            buf_config = c[i];
            @(posedge mclk) #1 `CHK({cfg_valid, big_depth}, {c[i] < 4'hc, d[i]})
        end
        buf_config = 4'h0;
        for (int s = 0; s < 8; s++)
        begin
            alt_setting = s[1:0]; hs_mode = s[2]; @(posedge mclk) #1
            `CHK(ep_type, ty[s % 4])
            `CHK(ep_maxpkt[29:10], {2{s == 5 ? 10'h200 : s % 4 ? 10'h040 : 10'h000}})
            if (s % 4 != 0)
                `CHK(ep_maxpkt[69:30], {4{s > 3 ? 10'h200 : 10'h040}})
        end
        alt_setting = 2'h0; hs_mode = 1'b1;
    endtask : t_cfg

    task automatic end_of_test;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    // main sequence
    initial
    begin
        repeat (20) @(posedge mclk);
        #1 sys_rst = 1'b0;
        t_ram; t_regs; t_loader; t_sie; t_cfg;
        end_of_test;
    end

    // watchdog
    initial
    begin
        #(100 * 5000);
        n_errors++;
        end_of_test;
    end
endmodule : epm_map_test

`default_nettype wire
